/* vci_inserter.sv */
// Caption and copy-word inserter for the vertical blanking lines
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module vci_inserter (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [4:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       line_start_i,
	input  wire logic [9:0] line_num_i,
	input  wire logic       odd_field_i,
	input  wire logic [7:0] pixel_i,
	output logic      [7:0] video_o,
	output logic            vbi_active_o
);
	import vci_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
		hit = (addr == off);
	endfunction : hit

	function automatic logic [7:0] runin_level(input logic [3:0] idx);
		case (idx)
			4'h0:    runin_level = 8'h40;
			4'h1:    runin_level = 8'h44;
			4'h2:    runin_level = 8'h50;
			4'h3:    runin_level = 8'h61;
			4'h4:    runin_level = 8'h78;
			4'h5:    runin_level = 8'h8F;
			4'h6:    runin_level = 8'hA0;
			4'h7:    runin_level = 8'hAC;
			4'h8:    runin_level = 8'hB0;
			4'h9:    runin_level = 8'hAC;
			4'hA:    runin_level = 8'hA0;
			4'hB:    runin_level = 8'h8F;
			4'hC:    runin_level = 8'h78;
			4'hD:    runin_level = 8'h61;
			4'hE:    runin_level = 8'h50;
			default: runin_level = 8'h44;
		endcase
	endfunction : runin_level

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] cc_even_0_reg;
	logic [7:0] cc_even_1_reg;
	logic [7:0] cc_odd_0_reg;
	logic [7:0] cc_odd_1_reg;
	logic [7:0] cgms_wss_0_reg;
	logic [7:0] cgms_wss_1_reg;
	logic [7:0] cgms_wss_data_2_reg;
	logic [7:0] std_ctrl_reg;
	logic [7:0] rdata_next;
	logic [7:0] status_w;

	wire wr_cc_even_0 = reg_wr_i && hit(reg_addr_i, OFF_CC_EVEN_0);
	wire wr_cc_even_1 = reg_wr_i && hit(reg_addr_i, OFF_CC_EVEN_1);
	wire wr_cc_odd_0  = reg_wr_i && hit(reg_addr_i, OFF_CC_ODD_0);
	wire wr_cc_odd_1  = reg_wr_i && hit(reg_addr_i, OFF_CC_ODD_1);
	wire wr_cw_0      = reg_wr_i && hit(reg_addr_i, OFF_CGMS_WSS_0);
	wire wr_cw_1      = reg_wr_i && hit(reg_addr_i, OFF_CGMS_WSS_1);
	wire wr_cw_2      = reg_wr_i && hit(reg_addr_i, OFF_CGMS_WSS_DATA_2);
	wire wr_std       = reg_wr_i && hit(reg_addr_i, OFF_STD_CTRL);

	wire crc_auto_enable        = cgms_wss_0_reg[BIT_CRC_AUTO_EN];
	wire odd_field_copy_enable  = cgms_wss_0_reg[BIT_ODD_COPY_EN];
	wire even_field_copy_enable = cgms_wss_0_reg[BIT_EVEN_COPY_EN];
	wire ntsc_mode              = std_ctrl_reg[BIT_STD_NTSC];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cc_even_0_reg       <= RST_DATA;
			cc_even_1_reg       <= RST_DATA;
			cc_odd_0_reg        <= RST_DATA;
			cc_odd_1_reg        <= RST_DATA;
			cgms_wss_0_reg      <= RST_DATA;
			cgms_wss_1_reg      <= RST_DATA;
			cgms_wss_data_2_reg <= RST_DATA;
			std_ctrl_reg        <= RST_STD_CTRL;
		end else begin
			if (wr_cc_even_0) cc_even_0_reg <= reg_wdata_i;
			if (wr_cc_even_1) cc_even_1_reg <= reg_wdata_i;
			if (wr_cc_odd_0) cc_odd_0_reg <= reg_wdata_i;
			if (wr_cc_odd_1) cc_odd_1_reg <= reg_wdata_i;
			if (wr_cw_0) cgms_wss_0_reg <= reg_wdata_i;
			if (wr_cw_1) cgms_wss_1_reg <= reg_wdata_i;
			if (wr_cw_2) cgms_wss_data_2_reg <= reg_wdata_i;
			if (wr_std) std_ctrl_reg <= {7'h00, reg_wdata_i[BIT_STD_NTSC]};
		end
	end

	// ------------------------------------------------------------
	// Line decode and copy word assembly
	// ------------------------------------------------------------
	logic [5:0] crc_w;

	wire cc_odd_line  = odd_field_i && (line_num_i == LINE_CC_ODD);
	wire cc_even_line = !odd_field_i && (line_num_i == LINE_CC_EVEN);
	wire cc_hit       = cc_odd_line || cc_even_line;
	wire cgms_hit     = ntsc_mode && ((odd_field_i && (line_num_i == LINE_CGMS_ODD)
	                    && odd_field_copy_enable) || (!odd_field_i
	                    && (line_num_i == LINE_CGMS_EVEN) && even_field_copy_enable));

	// C0-C7 from register 2, C8-C15 register 1, C16-C19 register 0
	wire [19:0] copy_word_bits = {cgms_wss_0_reg[3:0], cgms_wss_1_reg,
	                              cgms_wss_data_2_reg};

	vci_crc6 u_crc (
		.data_i (copy_word_bits[13:0]),
		.crc_o  (crc_w)
	);

	// Check sequence sent first-out bit as C14
	wire [5:0]  crc_rev   = {crc_w[0], crc_w[1], crc_w[2], crc_w[3], crc_w[4], crc_w[5]};
	wire [19:0] cgms_load = crc_auto_enable ? {crc_rev, copy_word_bits[13:0]}
	                                        : copy_word_bits;
	wire [15:0] cc_load   = cc_odd_line ? {cc_odd_1_reg, cc_odd_0_reg}
	                                    : {cc_even_1_reg, cc_even_0_reg};

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	vci_state_e  state_reg;
	vci_state_e  state_next;
	logic [19:0] shift_reg;
	logic [19:0] shift_next;
	logic [9:0]  cnt_reg;
	logic [9:0]  cnt_next;
	logic [4:0]  sub_reg;
	logic [4:0]  sub_next;
	logic [4:0]  bits_reg;
	logic [4:0]  bits_next;
	logic        kind_cc_reg;
	logic        kind_cc_next;
	logic        line_hold_reg;
	logic        line_hold_next;

	wire [4:0] bit_last = kind_cc_reg ? 5'(CC_BIT_CYC - 1) : 5'(CGMS_BIT_CYC - 1);
	wire       sub_end  = (sub_reg == bit_last);
	wire [4:0] data_last = kind_cc_reg ? 5'(CC_DATA_BITS - 1) : 5'(CGMS_DATA_BITS - 1);
	wire [3:0] runin_idx = 4'((32'(sub_reg) * 16) / CC_BIT_CYC);

	always_comb begin
		state_next     = state_reg;
		shift_next     = shift_reg;
		cnt_next       = cnt_reg;
		sub_next       = sub_end ? 5'h00 : sub_reg + 5'h01;
		bits_next      = bits_reg;
		kind_cc_next   = kind_cc_reg;
		line_hold_next = line_hold_reg;
		if (line_start_i) begin
			// Payload captured here, so earlier writes apply to this line
			line_hold_next = cc_hit;
			kind_cc_next   = cc_hit;
			sub_next       = 5'h00;
			bits_next      = 5'h00;
			if (cc_hit) begin
				state_next = ST_DELAY;
				cnt_next   = 10'(CC_DELAY_CYC - 1);
				shift_next = {4'h0, cc_load};
			end else if (cgms_hit) begin
				state_next = ST_DELAY;
				cnt_next   = 10'(CGMS_DELAY_CYC - 1);
				shift_next = cgms_load;
			end else begin
				state_next = ST_IDLE;
			end
		end else begin
			case (state_reg)
				ST_IDLE: begin
					sub_next = 5'h00;
				end
				ST_DELAY: begin
					sub_next = 5'h00;
					cnt_next = cnt_reg - 10'h001;
					if (cnt_reg == 10'h000) begin
						state_next = kind_cc_reg ? ST_RUNIN : ST_REF;
					end
				end
				ST_RUNIN: begin
					if (sub_end) begin
						bits_next = bits_reg + 5'h01;
						if (bits_reg == 5'(CC_RUNIN_BITS - 1)) begin
							state_next = ST_GAP;
							bits_next  = 5'h00;
						end
					end
				end
				ST_GAP: begin
					if (sub_end) begin
						bits_next = bits_reg + 5'h01;
						if (bits_reg == 5'(CC_GAP_BITS - 1)) begin
							state_next = ST_START;
							bits_next  = 5'h00;
						end
					end
				end
				ST_START: begin
					if (sub_end) begin
						state_next = ST_DATA;
					end
				end
				ST_REF: begin
					if (sub_end) begin
						state_next = ST_DATA;
					end
				end
				ST_DATA: begin
					if (sub_end) begin
						shift_next = {1'b0, shift_reg[19:1]};
						bits_next  = bits_reg + 5'h01;
						if (bits_reg == data_last) begin
							state_next = ST_IDLE;
							bits_next  = 5'h00;
						end
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg     <= ST_IDLE;
			shift_reg     <= 20'h00000;
			cnt_reg       <= 10'h000;
			sub_reg       <= 5'h00;
			bits_reg      <= 5'h00;
			kind_cc_reg   <= 1'b0;
			line_hold_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			shift_reg     <= shift_next;
			cnt_reg       <= cnt_next;
			sub_reg       <= sub_next;
			bits_reg      <= bits_next;
			kind_cc_reg   <= kind_cc_next;
			line_hold_reg <= line_hold_next;
		end
	end

	// ------------------------------------------------------------
	// Output level selection
	// ------------------------------------------------------------
	wire       cgms_drive = !kind_cc_reg && ((state_reg == ST_REF) || (state_reg == ST_DATA));
	wire [7:0] high_lvl   = kind_cc_reg ? LVL_CC_HIGH : LVL_CGMS_HIGH;
	logic [7:0] level_w;

	always_comb begin
		case (state_reg)
			ST_RUNIN: level_w = runin_level(runin_idx);
			ST_START: level_w = LVL_CC_HIGH;
			ST_REF:   level_w = LVL_CGMS_HIGH;
			ST_DATA:  level_w = shift_reg[0] ? high_lvl : LVL_BLANK;
			default:  level_w = LVL_BLANK;
		endcase
	end

	wire [7:0] video_next  = (line_hold_reg || cgms_drive) ? level_w : pixel_i;
	wire       active_next = line_hold_reg || cgms_drive;

	assign status_w   = {3'h0, line_hold_reg, kind_cc_reg, state_reg};
	assign rdata_next = hit(reg_addr_i, OFF_CC_EVEN_0)       ? cc_even_0_reg :
	                    hit(reg_addr_i, OFF_CC_EVEN_1)       ? cc_even_1_reg :
	                    hit(reg_addr_i, OFF_CC_ODD_0)        ? cc_odd_0_reg :
	                    hit(reg_addr_i, OFF_CC_ODD_1)        ? cc_odd_1_reg :
	                    hit(reg_addr_i, OFF_CGMS_WSS_0)      ? cgms_wss_0_reg :
	                    hit(reg_addr_i, OFF_CGMS_WSS_1)      ? cgms_wss_1_reg :
	                    hit(reg_addr_i, OFF_CGMS_WSS_DATA_2) ? cgms_wss_data_2_reg :
	                    hit(reg_addr_i, OFF_STD_CTRL)        ? std_ctrl_reg :
	                    hit(reg_addr_i, OFF_STATUS)          ? status_w : 8'h00;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			video_o      <= LVL_BLANK;
			vbi_active_o <= 1'b0;
			reg_rdata_o  <= 8'h00;
		end else begin
			video_o      <= video_next;
			vbi_active_o <= active_next;
			reg_rdata_o  <= reg_rd_i ? rdata_next : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_cc_line_start: assert property (
		line_start_i && cc_hit |=> state_reg == ST_DELAY && kind_cc_reg && line_hold_reg)
		else $error("caption line did not start the sequencer");

	chk_cgms_ntsc_gate: assert property (
		line_start_i && !cc_hit && !ntsc_mode |=> state_reg == ST_IDLE ##1 !vbi_active_o)
		else $error("copy word started outside NTSC");

	chk_runin_bits: assert property (
		state_reg == ST_RUNIN && state_next == ST_GAP && !line_start_i
		|-> bits_reg == 5'(CC_RUNIN_BITS - 1) && sub_end)
		else $error("run-in did not last seven bits");

	chk_gap_then_start: assert property (
		$rose(state_reg == ST_START) |-> $past(state_reg) == ST_GAP
		##1 video_o == LVL_CC_HIGH)
		else $error("start bit not after gap or not high");

	chk_gap_blank: assert property (
		state_reg == ST_GAP |=> video_o == LVL_BLANK)
		else $error("gap not at blanking level");

	chk_pixels_ignored: assert property (
		line_hold_reg && (state_reg == ST_IDLE || state_reg == ST_DELAY)
		|=> video_o == LVL_BLANK && vbi_active_o)
		else $error("pixel passed on caption line");

	chk_data_count: assert property (
		state_reg == ST_DATA && state_next == ST_IDLE && !line_start_i
		|-> bits_reg == data_last)
		else $error("wrong payload bit count");

	chk_cgms_ref_pulse: assert property (
		state_reg == ST_REF && !kind_cc_reg |=> video_o == LVL_CGMS_HIGH && vbi_active_o)
		else $error("reference pulse wrong level");

	chk_even_payload: assert property (
		line_start_i && cc_even_line
		|=> shift_reg[15:0] == {$past(cc_even_1_reg), $past(cc_even_0_reg)})
		else $error("even line payload not from extended registers");

	chk_crc_insert: assert property (
		line_start_i && !cc_hit && cgms_hit && crc_auto_enable
		|=> shift_reg[19:14] == $past(crc_rev) && shift_reg[13:0] == $past(copy_word_bits[13:0]))
		else $error("check sequence not inserted");

	chk_crc_bypass: assert property (
		line_start_i && !cc_hit && cgms_hit && !crc_auto_enable
		|=> shift_reg == $past(copy_word_bits))
		else $error("register bits altered with check off");

endmodule : vci_inserter

/* vci_pkg.sv */
// Package of constants for the blanking-interval caption and copy-word inserter
package vci_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [4:0] OFF_CC_EVEN_0      = 5'h0E;
	localparam logic [4:0] OFF_CC_EVEN_1      = 5'h0F;
	localparam logic [4:0] OFF_CC_ODD_0       = 5'h10;
	localparam logic [4:0] OFF_CC_ODD_1       = 5'h11;
	localparam logic [4:0] OFF_CGMS_WSS_0     = 5'h16;
	localparam logic [4:0] OFF_CGMS_WSS_1     = 5'h17;
	localparam logic [4:0] OFF_CGMS_WSS_DATA_2 = 5'h18;
	localparam logic [4:0] OFF_STD_CTRL       = 5'h1A;
	localparam logic [4:0] OFF_STATUS         = 5'h1B;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int       BIT_CRC_AUTO_EN   = 4;
	localparam int       BIT_ODD_COPY_EN   = 5;
	localparam int       BIT_EVEN_COPY_EN  = 6;
	localparam int       BIT_STD_NTSC      = 0;
	localparam logic [7:0] RST_DATA        = 8'h00;
	localparam logic [7:0] RST_STD_CTRL    = 8'h01;

	// ------------------------------------------------------------
	// Line numbers
	// ------------------------------------------------------------
	localparam logic [9:0] LINE_CC_ODD     = 10'h015;
	localparam logic [9:0] LINE_CC_EVEN    = 10'h11C;
	localparam logic [9:0] LINE_CGMS_ODD   = 10'h014;
	localparam logic [9:0] LINE_CGMS_EVEN  = 10'h11B;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS          = 100;
	localparam int CC_BIT_NS       = 1986;
	localparam int CGMS_BIT_NS     = 2237;
	localparam int CC_DELAY_NS     = 10500;
	localparam int CGMS_DELAY_NS   = 11200;
	localparam int CC_BIT_CYC      = CC_BIT_NS / CLK_NS;
	localparam int CGMS_BIT_CYC    = CGMS_BIT_NS / CLK_NS;
	localparam int CC_DELAY_CYC    = CC_DELAY_NS / CLK_NS;
	localparam int CGMS_DELAY_CYC  = CGMS_DELAY_NS / CLK_NS;
	localparam int CC_RUNIN_BITS   = 7;
	localparam int CC_GAP_BITS     = 2;
	localparam int CC_DATA_BITS    = 16;
	localparam int CGMS_DATA_BITS  = 20;
	localparam int CRC_DATA_BITS   = 14;

	// ------------------------------------------------------------
	// Output levels
	// ------------------------------------------------------------
	localparam logic [7:0] LVL_BLANK     = 8'h40;
	localparam logic [7:0] LVL_CC_HIGH   = 8'hB0;
	localparam logic [7:0] LVL_CGMS_HIGH = 8'hD0;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_DELAY = 3'h1,
		ST_RUNIN = 3'h3,
		ST_GAP   = 3'h2,
		ST_START = 3'h6,
		ST_DATA  = 3'h7,
		ST_REF   = 3'h5
	} vci_state_e;

endpackage : vci_pkg

/* vci_crc6.sv */
// Six-bit check sequence over the fourteen low copy-word bits
`timescale 1ns/10ps
module vci_crc6 (
	input  wire logic [13:0] data_i,
	output logic      [5:0]  crc_o
);
	import vci_pkg::*;

	// ------------------------------------------------------------
	// Serial x^6 + x + 1, preset all ones, bit 0 first
	// ------------------------------------------------------------
	always_comb begin
		logic [5:0] acc;
		logic       fb;
		acc = 6'h3F;
		fb  = 1'b0;
		for (int i = 0; i < CRC_DATA_BITS; i++) begin
			fb  = data_i[i] ^ acc[5];
			acc = {acc[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
		end
		crc_o = acc;
	end

endmodule : vci_crc6

/* vci_rx_model.sv */
// Receiver model that decodes caption and copy-word lines from the video output
`timescale 1ns/10ps
module vci_rx_model
	import vci_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        line_start_i,
	input  wire logic [9:0]  line_num_i,
	input  wire logic        odd_field_i,
	input  wire logic [7:0]  video_i,
	input  wire logic        vbi_active_i,
	output logic      [19:0] word_o,
	output logic             frame_ok_o,
	output int               lit_o
);
	int   t;
	int   k;
	logic cc;
	logic cg;

	// ------------------------------------------------------------
	// Mid-bit slicer, counted from the line start pulse
	// ------------------------------------------------------------
	always @(negedge clk_i) begin
		if (line_start_i) begin
			t = 0;
			lit_o = 0;
			word_o = '0;
			frame_ok_o = 1'b1;
			cc = (odd_field_i && line_num_i == LINE_CC_ODD) || (!odd_field_i && line_num_i == LINE_CC_EVEN);
			cg = (odd_field_i && line_num_i == LINE_CGMS_ODD) || (!odd_field_i && line_num_i == LINE_CGMS_EVEN);
		end else begin
			t = t + 1;
			// First cycle still shows the previous line's flag
			if (vbi_active_i === 1'b1 && t > 1) lit_o = lit_o + 1;
			if (cc && t >= 117 && (t - 117) % 19 == 0 && t <= 117 + 25 * 19) begin
				k = (t - 117) / 19;
				if (k >= 10) word_o[k-10] = (video_i === LVL_CC_HIGH);
				else if (k >= 7) frame_ok_o &= (video_i === ((k == 9) ? LVL_CC_HIGH : LVL_BLANK));
			end
			if (cg && t >= 126 && (t - 126) % 22 == 0 && t <= 126 + 20 * 22) begin
				k = (t - 126) / 22;
				if (k > 0) word_o[k-1] = (video_i === LVL_CGMS_HIGH);
				else frame_ok_o &= (video_i === LVL_CGMS_HIGH);
			end
		end
	end
endmodule : vci_rx_model

/* vci_inserter_test.sv */
// Self-checking bench for the caption and copy-word inserter
`timescale 1ns/10ps
module vci_inserter_test;
	import vci_pkg::*;
	logic        clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic        line_start_i = 0, odd_field_i = 0, vbi_active_o, ok;
	logic [4:0]  reg_addr_i = '0;
	logic [7:0]  reg_wdata_i = '0, reg_rdata_o, pixel_i = '0, video_o, d;
	logic [9:0]  line_num_i = '0;
	logic [19:0] word, exp_w;
	logic [7:0]  mir [32];
	logic [4:0]  offs [8] = '{5'h0E, 5'h0F, 5'h10, 5'h11, 5'h16, 5'h17, 5'h18, 5'h1A};
	int          errors = 0, tests_run = 0, seed = 46, lit;

	vci_inserter dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .line_start_i(line_start_i), .line_num_i(line_num_i),
		.odd_field_i(odd_field_i), .pixel_i(pixel_i), .video_o(video_o),
		.vbi_active_o(vbi_active_o));
	vci_rx_model rx_u (.clk_i(clk_i), .line_start_i(line_start_i), .line_num_i(line_num_i),
		.odd_field_i(odd_field_i), .video_i(video_o), .vbi_active_i(vbi_active_o),
		.word_o(word), .frame_ok_o(ok), .lit_o(lit));

	initial begin
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) pixel_i <= 8'($random(seed));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		mir[a] = (a == OFF_STD_CTRL) ? (v & 8'h01) : v;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		check({12'h000, reg_rdata_o}, {12'h000, exp});
	endtask : rd
	task automatic run_line(input logic [9:0] n, input logic odd, input int late);
		@(posedge clk_i);
		line_start_i <= 1'b1;
		line_num_i <= n;
		odd_field_i <= odd;
		@(posedge clk_i);
		line_start_i <= 1'b0;
		if (late > 0) begin
			repeat (late) @(posedge clk_i);
			wr(OFF_CC_ODD_0, 8'hFF);
		end
		repeat (690) @(posedge clk_i);
		@(negedge clk_i);
	endtask : run_line
	// Copy word as sent, with the six check bits regenerated when enabled
	function automatic logic [19:0] copy_word();
		logic [19:0] w;
		logic [5:0]  s;
		logic        fb;
		w = {mir[OFF_CGMS_WSS_0][3:0], mir[OFF_CGMS_WSS_1], mir[OFF_CGMS_WSS_DATA_2]};
		if (mir[OFF_CGMS_WSS_0][BIT_CRC_AUTO_EN]) begin
			s = 6'h3F;
			for (int i = 0; i < 14; i++) begin
				fb = w[i] ^ s[5];
				s = {s[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
			end
			for (int j = 0; j < 6; j++) w[14+j] = s[5-j];
		end
		return w;
	endfunction : copy_word
	task automatic close_out();
		$display("checks=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 8; i++) rd(offs[i], (i == 7) ? RST_STD_CTRL : RST_DATA);
		wr(5'h1C, 8'hA5);
		rd(5'h1C, 8'h00);
		for (int i = 0; i < 7; i++) begin
			d = 8'($random(seed));
			wr(offs[i], d);
			rd(offs[i], d);
		end
		$display("test registers done");
		for (int f = 0; f < 2; f++) begin
			wr(f ? OFF_CC_ODD_0 : OFF_CC_EVEN_0, 8'($random(seed)));
			wr(f ? OFF_CC_ODD_1 : OFF_CC_EVEN_1, 8'($random(seed)));
			exp_w = f ? {4'h0, mir[OFF_CC_ODD_1], mir[OFF_CC_ODD_0]}
				: {4'h0, mir[OFF_CC_EVEN_1], mir[OFF_CC_EVEN_0]};
			run_line(f ? 10'd21 : 10'd284, f[0], f ? 40 : 0);
			check(word, exp_w);
			check({19'h0, ok}, 20'h1);
			check({19'h0, lit >= 680}, 20'h1);
		end
		wr(OFF_CC_ODD_0, 8'h00);
		wr(OFF_CC_ODD_1, 8'h00);
		run_line(10'd21, 1'b1, 0);
		check(word, 20'h0);
		check({19'h0, ok}, 20'h1);
		run_line(10'd21, 1'b0, 0);
		check(20'(lit), 20'h0);
		$display("test captions done");
		for (int m = 0; m < 8; m++) begin
			wr(OFF_CGMS_WSS_0, {1'b0, m[1:0] == 2'b00, m[2:1], 4'($random(seed))});
			wr(OFF_CGMS_WSS_1, 8'($random(seed)));
			wr(OFF_CGMS_WSS_DATA_2, 8'($random(seed)));
			for (int f = 0; f < 2; f++) begin
				run_line(f ? 10'd20 : 10'd283, f[0], 0);
				d = {7'h0, mir[OFF_CGMS_WSS_0][f ? BIT_ODD_COPY_EN : BIT_EVEN_COPY_EN]};
				check(20'(lit), d[0] ? 20'd462 : 20'd0);
				if (d[0]) check(word, copy_word());
				if (d[0]) check({19'h0, ok}, 20'h1);
			end
		end
		$display("test copy words done");
		wr(OFF_CGMS_WSS_0, 8'h60);
		wr(OFF_STD_CTRL, 8'h00);
		run_line(10'd20, 1'b1, 0);
		check(20'(lit), 20'h0);
		wr(OFF_STD_CTRL, 8'hFF);
		rd(OFF_STD_CTRL, 8'h01);
		$display("test standard done");
		close_out();
	end
endmodule : vci_inserter_test
